// ==== logic/smcg_defs.svh ====
`ifndef SMCG_DEFS_SVH
`define SMCG_DEFS_SVH
`define SMCG_ADDR_SLEEP_CTRL 2'h0
`define SMCG_ADDR_CLK_GATE 2'h1
`define SMCG_ADDR_STATUS 2'h2
`define SMCG_SE_BIT 0
`define SMCG_SM_LSB 1
`define SMCG_SM_MSB 3
`define SMCG_GATE_IMPL_MASK 8'h1F
`define SMCG_CTRL_MASK 8'h0F
`define SMCG_GATE_CONV 0
`define SMCG_GATE_USART 1
`define SMCG_GATE_SPI 2
`define SMCG_GATE_TIMER1 3
`define SMCG_GATE_DISPLAY 4
`define SMCG_RESET_BYTE 8'h00
`define SMCG_HALT_EXTRA 4'h4
`define SMCG_STANDBY_WAKE 4'h6
`endif

// ==== logic/smcg_pkg.sv ====
package smcg_pkg;
  typedef enum logic [2:0] {
    SMCG_MODE_IDLE = 3'h0,
    SMCG_MODE_NOISE = 3'h1,
    SMCG_MODE_PDOWN = 3'h2,
    SMCG_MODE_PSAVE = 3'h3,
    SMCG_MODE_STANDBY = 3'h6
  } smcg_mode_t;
  typedef enum logic [1:0] {
    SMCG_ST_RUN,
    SMCG_ST_SLEEP,
    SMCG_ST_START,
    SMCG_ST_HALT
  } smcg_state_t;
endpackage : smcg_pkg

// ==== logic/smcg_top.sv ====
// Contract
// - Sleep only when enable bit set.
// - Mode 000 idle: stop core and flash.
// - Hold core four cycles after start-up.
// - Mode 001 halts io, core, flash.
// - Noise mode starts conversion if enabled.
// - Noise mode limited wake-up source set.
// - Mode 010 power-down stops all clocks.
// - Power-down wakes on level, not edge.
// - Power-down wake waits start-up period.
// - Mode 011 power-save keeps timer2, display.
// - Save mode timer2 wake needs enables.
// - Save mode oscillators follow module clocks.
// - Mode 110 standby keeps oscillator, six cycles; the start state here lasts seven.
// - Gate bit stops clock, blocks access.
// - Clearing gate bit resumes frozen state.
// - Gating acts in active, idle only.
// - Gate bits 7..5 read zero.
// - Bit 4 gates display controller.
// - Bit 3 gates timer 1.
// - Bit 2 gates serial peripheral interface.
// - Bit 1 gates the USART.
// - Bit 0 gates converter, blocks comparator.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`include "smcg_defs.svh"
module smcg_top #(
  parameter int STARTUP_CYCLES = 16,
  parameter int NUM_GATES = 5
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sleep_instr,
  input wire logic crystal_selected,
  input wire logic converter_enabled,
  input wire logic global_irq_enable,
  input wire logic [1:0] timer2_irq_mask_reg,
  input wire logic timer2_running,
  input wire logic display_running,
  input wire logic timer2_async,
  input wire logic display_async,
  input wire logic wake_conv_done,
  input wire logic wake_display,
  input wire logic wake_start_cond,
  input wire logic [1:0] wake_timer2,
  input wire logic wake_nvm_ready,
  input wire logic wake_line0_level,
  input wire logic wake_line0_edge,
  input wire logic wake_pin_change,
  input wire logic wake_other_io,
  output logic core_clk_en,
  output logic flash_clk_en,
  output logic io_clk_en,
  output logic conv_clk_en,
  output logic async_clk_en,
  output logic main_osc_en,
  output logic timer_osc_en,
  output logic sync_only_t2_disp,
  output logic conv_start,
  output logic [NUM_GATES-1:0] periph_clk_en,
  output logic comparator_mux_allowed,
  output logic irq_service
);
  smcg_pkg::smcg_state_t st_reg, st_next;
  logic [2:0] mode_reg;
  logic [7:0] sleep_ctrl_reg;
  logic [NUM_GATES-1:0] gate_reg;
  logic [15:0] cnt_reg, cnt_next;
  logic [7:0] rdata_next;
  wire [2:0] sm_sel = sleep_ctrl_reg[`SMCG_SM_MSB:`SMCG_SM_LSB];
  wire se = sleep_ctrl_reg[`SMCG_SE_BIT];
  wire wr_ctrl = reg_wr && reg_addr == `SMCG_ADDR_SLEEP_CTRL;
  wire wr_gate = reg_wr && reg_addr == `SMCG_ADDR_CLK_GATE;
  wire sm_valid = sm_sel == smcg_pkg::SMCG_MODE_IDLE ||
    sm_sel == smcg_pkg::SMCG_MODE_NOISE ||
    sm_sel == smcg_pkg::SMCG_MODE_PDOWN ||
    sm_sel == smcg_pkg::SMCG_MODE_PSAVE ||
    (sm_sel == smcg_pkg::SMCG_MODE_STANDBY && crystal_selected);
  wire enter = st_reg == smcg_pkg::SMCG_ST_RUN && sleep_instr && se &&
    sm_valid;
  // Entry uses the new mode so clock enables drop with the state change.
  wire [2:0] mode_eff = enter ? sm_sel : mode_reg;
  wire m_idle = mode_eff == smcg_pkg::SMCG_MODE_IDLE;
  wire m_noise = mode_eff == smcg_pkg::SMCG_MODE_NOISE;
  wire m_pdown = mode_eff == smcg_pkg::SMCG_MODE_PDOWN;
  wire m_psave = mode_eff == smcg_pkg::SMCG_MODE_PSAVE;
  wire m_stby = mode_eff == smcg_pkg::SMCG_MODE_STANDBY;
  wire asleep_next = st_next != smcg_pkg::SMCG_ST_RUN;
  wire deep = asleep_next && !m_idle;
  // timer 2 wake needs both enables
  wire t2_wake = global_irq_enable && |(wake_timer2 & timer2_irq_mask_reg);
  // only level on line 0; edge ignored
  wire wake_base = wake_start_cond || wake_line0_level || wake_pin_change;
  wire wake_noise = wake_base || wake_conv_done || wake_display ||
    |wake_timer2 || wake_nvm_ready;
  wire wake_idle = wake_noise || wake_line0_edge || wake_other_io;
  wire wake_psave = wake_base || t2_wake || wake_display;
  wire wake_now = m_idle ? wake_idle : m_noise ? wake_noise :
    m_psave ? wake_psave : wake_base;
  wire [15:0] start_len = m_stby ? 16'(`SMCG_STANDBY_WAKE) :
    (m_pdown || (m_psave && !timer2_running && !display_running) ||
     m_psave) ? 16'(STARTUP_CYCLES) : 16'h0000;
  always_comb
  begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    case (st_reg)
      smcg_pkg::SMCG_ST_RUN:
        if (enter)
          st_next = smcg_pkg::SMCG_ST_SLEEP;
      smcg_pkg::SMCG_ST_SLEEP:
        if (wake_now)
        begin
          st_next = smcg_pkg::SMCG_ST_START;
          cnt_next = start_len;
        end
      smcg_pkg::SMCG_ST_START:
        if (cnt_reg == 16'h0000)
        begin
          st_next = smcg_pkg::SMCG_ST_HALT;
          cnt_next = 16'(`SMCG_HALT_EXTRA) - 16'h0001;
        end
        else
          cnt_next = cnt_reg - 16'h0001;
      smcg_pkg::SMCG_ST_HALT:
        if (cnt_reg == 16'h0000)
          st_next = smcg_pkg::SMCG_ST_RUN;
        else
          cnt_next = cnt_reg - 16'h0001;
      default:
        st_next = smcg_pkg::SMCG_ST_RUN;
    endcase
  end
  assign rdata_next = reg_addr == `SMCG_ADDR_SLEEP_CTRL ? sleep_ctrl_reg :
    reg_addr == `SMCG_ADDR_CLK_GATE ?
      (8'(gate_reg) & `SMCG_GATE_IMPL_MASK) :
    reg_addr == `SMCG_ADDR_STATUS ? {3'h0, mode_reg, 2'(st_reg)} :
    `SMCG_RESET_BYTE;
  wire run_sync = (timer2_running && !timer2_async) ||
    (display_running && !display_async);
  wire run_async = (timer2_running && timer2_async) ||
    (display_running && display_async);
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg <= smcg_pkg::SMCG_ST_RUN;
      cnt_reg <= 16'h0000;
      mode_reg <= 3'h0;
      sleep_ctrl_reg <= `SMCG_RESET_BYTE;
      gate_reg <= '0;
      reg_rdata <= `SMCG_RESET_BYTE;
    end
    else
    begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      if (enter)
        mode_reg <= sm_sel;
      if (wr_ctrl)
        sleep_ctrl_reg <= reg_wdata & `SMCG_CTRL_MASK;
      if (wr_gate)
        gate_reg <= reg_wdata[NUM_GATES-1:0];
      reg_rdata <= reg_rd ? rdata_next : `SMCG_RESET_BYTE;
    end
  end
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      core_clk_en <= 1'b1;
      flash_clk_en <= 1'b1;
      io_clk_en <= 1'b1;
      conv_clk_en <= 1'b1;
      async_clk_en <= 1'b1;
      main_osc_en <= 1'b1;
      timer_osc_en <= 1'b1;
      sync_only_t2_disp <= 1'b0;
      conv_start <= 1'b0;
      irq_service <= 1'b0;
      comparator_mux_allowed <= 1'b1;
    end
    else
    begin
      core_clk_en <= st_next == smcg_pkg::SMCG_ST_RUN;
      flash_clk_en <= st_next == smcg_pkg::SMCG_ST_RUN;
      io_clk_en <= !deep;
      conv_clk_en <= !(deep && !m_noise);
      async_clk_en <= !(deep && (m_pdown || m_stby) &&
        st_next == smcg_pkg::SMCG_ST_SLEEP);
      main_osc_en <= !(st_next == smcg_pkg::SMCG_ST_SLEEP &&
        (m_pdown || (m_psave && !run_sync)));
      timer_osc_en <= !(st_next == smcg_pkg::SMCG_ST_SLEEP &&
        (m_pdown || m_stby || (m_psave && !run_async)));
      sync_only_t2_disp <= st_next == smcg_pkg::SMCG_ST_SLEEP &&
        m_psave && run_sync;
      conv_start <= enter && sm_sel == smcg_pkg::SMCG_MODE_NOISE &&
        converter_enabled && !gate_reg[`SMCG_GATE_CONV];
      irq_service <= st_reg == smcg_pkg::SMCG_ST_HALT &&
        st_next == smcg_pkg::SMCG_ST_RUN;
      comparator_mux_allowed <= !gate_reg[`SMCG_GATE_CONV];
    end
  end
  genvar g;
  generate
    for (g = 0; g < NUM_GATES; g++)
    begin : g_gate
      always_ff @(posedge sys_clk or negedge resetn)
      begin
        if (!resetn)
          periph_clk_en[g] <= 1'b1;
        else
          periph_clk_en[g] <= !(wr_gate ? reg_wdata[g] : gate_reg[g]) &&
            !deep;
      end
    end
  endgenerate
  a_no_sleep_clear: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (sleep_instr && !se) |=> st_reg != smcg_pkg::SMCG_ST_SLEEP ||
    $past(st_reg) != smcg_pkg::SMCG_ST_RUN)
    else $error("Slept with enable clear.");
  a_halt_four: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    $rose(st_reg == smcg_pkg::SMCG_ST_HALT) |->
    (st_reg == smcg_pkg::SMCG_ST_HALT)[*4] ##1
    st_reg == smcg_pkg::SMCG_ST_RUN)
    else $error("Halt not four cycles.");
  a_irq_pulse: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    irq_service |-> core_clk_en && st_reg == smcg_pkg::SMCG_ST_RUN ##1
    !irq_service)
    else $error("Service pulse wrong.");
  a_edge_ignored: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (st_reg == smcg_pkg::SMCG_ST_SLEEP && m_pdown && wake_line0_edge &&
    !wake_base) |=> st_reg == smcg_pkg::SMCG_ST_SLEEP)
    else $error("Edge woke power-down.");
  a_noise_wake: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (st_reg == smcg_pkg::SMCG_ST_SLEEP && m_noise && !wake_conv_done &&
    !wake_display && !wake_start_cond && wake_timer2 == 2'h0 &&
    !wake_nvm_ready && !wake_line0_level && !wake_pin_change) |=>
    st_reg == smcg_pkg::SMCG_ST_SLEEP)
    else $error("Noise mode woke by other source.");
  a_t2_enable: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (st_reg == smcg_pkg::SMCG_ST_SLEEP && m_psave && !global_irq_enable &&
    !wake_base && !wake_display) |=> st_reg == smcg_pkg::SMCG_ST_SLEEP)
    else $error("Timer2 woke without enable.");
  a_stby_six: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (st_reg == smcg_pkg::SMCG_ST_SLEEP && m_stby && wake_base) |=>
    (st_reg == smcg_pkg::SMCG_ST_START)[*7] ##1
    st_reg == smcg_pkg::SMCG_ST_HALT)
    else $error("Standby start length wrong.");
  a_stby_osc: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (st_reg == smcg_pkg::SMCG_ST_SLEEP && m_stby) |->
    main_osc_en && !io_clk_en && !timer_osc_en)
    else $error("Standby oscillator stopped.");
  a_pdown_wake: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (st_reg == smcg_pkg::SMCG_ST_SLEEP && m_pdown && wake_base) |=>
    st_reg == smcg_pkg::SMCG_ST_START && cnt_reg == 16'(STARTUP_CYCLES))
    else $error("Power-down start-up period wrong.");
  a_idle_clocks: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (st_reg == smcg_pkg::SMCG_ST_SLEEP && m_idle) |-> !core_clk_en &&
    !flash_clk_en && io_clk_en && conv_clk_en && main_osc_en)
    else $error("Idle clock domains wrong.");
  a_noise_io: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (st_reg == smcg_pkg::SMCG_ST_SLEEP && m_noise) |->
    !io_clk_en && !core_clk_en && conv_clk_en && async_clk_en)
    else $error("Noise mode clock domains wrong.");
  a_psave_keep: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (st_reg == smcg_pkg::SMCG_ST_SLEEP && m_psave) |->
    async_clk_en && !conv_clk_en && !io_clk_en)
    else $error("Power-save clock domains wrong.");
  a_psave_osc: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (st_reg == smcg_pkg::SMCG_ST_SLEEP && m_psave) |->
    main_osc_en == $past(run_sync) && timer_osc_en == $past(run_async))
    else $error("Power-save oscillators wrong.");
  a_pdown_osc: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (st_reg == smcg_pkg::SMCG_ST_SLEEP && m_pdown && !wake_base) |=>
    !main_osc_en && !conv_clk_en)
    else $error("Power-down clocks running.");
  a_noise_conv: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (enter && sm_sel == smcg_pkg::SMCG_MODE_NOISE && converter_enabled &&
    !gate_reg[`SMCG_GATE_CONV]) |=> conv_start)
    else $error("No conversion started.");
  a_gate_read: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    reg_rd |=> reg_rdata[7:5] == 3'h0 ||
    $past(reg_addr) != `SMCG_ADDR_CLK_GATE)
    else $error("Reserved gate bits nonzero.");
  a_gate_write: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (wr_gate && st_next == smcg_pkg::SMCG_ST_RUN) |=>
    periph_clk_en == ~$past(reg_wdata[NUM_GATES-1:0]))
    else $error("Gate write not applied.");
  a_gate_hold: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (st_reg == smcg_pkg::SMCG_ST_RUN && st_next == smcg_pkg::SMCG_ST_RUN &&
    !wr_gate) |=> periph_clk_en == ~gate_reg)
    else $error("Module clocks not following gate.");
  a_gate_active: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (st_reg == smcg_pkg::SMCG_ST_SLEEP && !m_idle) |->
    periph_clk_en == '0)
    else $error("Module clock running in deep sleep.");
  a_display_gate: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (st_reg == smcg_pkg::SMCG_ST_RUN && gate_reg[`SMCG_GATE_DISPLAY] &&
    !wr_gate) |=> !periph_clk_en[`SMCG_GATE_DISPLAY])
    else $error("Display clock not gated.");
  a_gate_clk: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (st_reg == smcg_pkg::SMCG_ST_RUN && gate_reg[`SMCG_GATE_TIMER1] &&
    !wr_gate) |=> !periph_clk_en[`SMCG_GATE_TIMER1])
    else $error("Timer1 clock not gated.");
  a_spi_gate: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (st_reg == smcg_pkg::SMCG_ST_RUN && gate_reg[`SMCG_GATE_SPI] &&
    !wr_gate) |=> !periph_clk_en[`SMCG_GATE_SPI])
    else $error("Serial interface clock not gated.");
  a_usart_gate: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (st_reg == smcg_pkg::SMCG_ST_RUN && gate_reg[`SMCG_GATE_USART] &&
    !wr_gate) |=> !periph_clk_en[`SMCG_GATE_USART])
    else $error("USART clock not gated.");
  a_conv_mux: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    gate_reg[`SMCG_GATE_CONV] |=> !comparator_mux_allowed)
    else $error("Comparator kept converter input.");
  a_reserved_mode: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (st_reg == smcg_pkg::SMCG_ST_RUN && !sm_valid) |=>
    st_reg == smcg_pkg::SMCG_ST_RUN)
    else $error("Reserved mode slept.");
  c_idle: cover property (@(posedge sys_clk) enter && sm_sel == 3'h0);
  c_pdown: cover property (@(posedge sys_clk) enter && sm_sel == 3'h2);
  c_noise: cover property (@(posedge sys_clk) enter && m_noise);
  c_stby: cover property (@(posedge sys_clk) enter && m_stby);
  c_wake: cover property (@(posedge sys_clk) irq_service);
endmodule : smcg_top

// ==== test/smcg_core_model.sv ====
`timescale 1ns/1ns
module smcg_core_model #(
  parameter int HOLD = 12
) (
  input wire logic sys_clk,
  input wire logic level_req,
  output logic wake_line0_level
);
  int cnt = 0;
  // level held long
  // A level wake request stays up long enough to outlast the start-up wait.
  always @(posedge sys_clk)
  begin
    if (level_req)
      cnt <= HOLD;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  assign wake_line0_level = (cnt > 0);
endmodule : smcg_core_model

// ==== test/tb_top.sv ====
`timescale 1ns/1ns
`include "smcg_defs.svh"
module tb_top;
  localparam int SU = 2;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic sleep_instr = 1'b0, crystal_selected = 1'b0;
  logic converter_enabled = 1'b0, global_irq_enable = 1'b1;
  logic [1:0] timer2_irq_mask_reg = 2'h0, wake_timer2 = 2'h0;
  logic timer2_running = 1'b0, display_running = 1'b0;
  logic timer2_async = 1'b0, display_async = 1'b0;
  logic wake_conv_done = 1'b0, wake_display = 1'b0;
  logic wake_start_cond = 1'b0, wake_nvm_ready = 1'b0;
  logic wake_line0_level, wake_line0_edge = 1'b0;
  logic wake_pin_change = 1'b0, wake_other_io = 1'b0, lreq = 1'b0;
  logic core_clk_en, flash_clk_en, io_clk_en, conv_clk_en;
  logic async_clk_en, main_osc_en, timer_osc_en, sync_only_t2_disp;
  logic conv_start, comparator_mux_allowed, irq_service;
  logic [4:0] periph_clk_en;
  logic [7:0] rd;
  int fail_count = 0, samples_checked = 0, conv_seen = 0;
  wire [7:0] clks = {2'h0, core_clk_en, flash_clk_en, io_clk_en,
    conv_clk_en, async_clk_en, main_osc_en};

  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    if (conv_start === 1'b1)
      conv_seen++;

  smcg_top #(.STARTUP_CYCLES(SU)) u_smcg_top (.sys_clk, .resetn,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_instr,
    .crystal_selected, .converter_enabled, .global_irq_enable,
    .timer2_irq_mask_reg, .timer2_running, .display_running,
    .timer2_async, .display_async, .wake_conv_done, .wake_display,
    .wake_start_cond, .wake_timer2, .wake_nvm_ready, .wake_line0_level,
    .wake_line0_edge, .wake_pin_change, .wake_other_io, .core_clk_en,
    .flash_clk_en, .io_clk_en, .conv_clk_en, .async_clk_en, .main_osc_en,
    .timer_osc_en, .sync_only_t2_disp, .conv_start, .periph_clk_en,
    .comparator_mux_allowed, .irq_service);
  smcg_core_model #(.HOLD(6)) u_smcg_core_model (.sys_clk, .level_req(lreq),
    .wake_line0_level);

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic chk(input string n, input logic [7:0] e,
    input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [1:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask : rdr

  task automatic sleep(input logic [2:0] m, input logic en);
    wr(`SMCG_ADDR_SLEEP_CTRL, {4'h0, m, en});
    sleep_instr <= 1'b1;
    @(posedge sys_clk);
    sleep_instr <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : sleep

  task automatic stays;
    repeat (8) @(posedge sys_clk);
    #1;
    chk("core held asleep", 8'h00, {7'h0, core_clk_en});
  endtask : stays

  task automatic wake_time(input int lo);
    int n;
    n = 0;
    while (irq_service !== 1'b1 && n < 60)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("wake delay", 8'h01, 8'((n >= lo) && (n <= lo + 4)));
    chk("core clock back", 8'h01, {7'h0, core_clk_en});
    if (n == 60)
      print_verdict();
  endtask : wake_time

  initial
  begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    rdr(`SMCG_ADDR_CLK_GATE);
    chk("gate reset", `SMCG_RESET_BYTE, rd);
    wr(`SMCG_ADDR_CLK_GATE, 8'hFF);
    rdr(`SMCG_ADDR_CLK_GATE);
    chk("gate readback", 8'h1F, rd);
    chk("periph clocks", 8'h00, {3'h0, periph_clk_en});
    chk("mux allowed", 8'h00, {7'h0, comparator_mux_allowed});
    // Peripherals are treated as idle here before each clock is stopped.
    for (int i = 0; i < 5; i++)
    begin
      wr(`SMCG_ADDR_CLK_GATE, 8'h01 << i);
      @(posedge sys_clk);
      #1;
      chk("gate bit", 8'h1F ^ (8'h01 << i),
        {3'h0, periph_clk_en});
    end
    wr(`SMCG_ADDR_CLK_GATE, 8'h00);
    rdr(`SMCG_ADDR_CLK_GATE);
    chk("gate released", 8'h1F, {3'h0, periph_clk_en});
    sleep(3'h0, 1'b0);
    chk("no enable", 8'h01, {7'h0, core_clk_en});
    sleep(3'h4, 1'b1);
    chk("reserved mode", 8'h01, {7'h0, core_clk_en});
    sleep(3'h6, 1'b1);
    chk("standby no crystal", 8'h01, {7'h0, core_clk_en});
    wr(`SMCG_ADDR_CLK_GATE, 8'h08);
    sleep(3'h0, 1'b1);
    chk("idle clocks", 8'h0F, clks);
    chk("idle gating", 8'h17, {3'h0, periph_clk_en});
    wake_other_io <= 1'b1;
    wake_time(4);
    wake_other_io <= 1'b0;
    wr(`SMCG_ADDR_CLK_GATE, 8'h00);
    converter_enabled <= 1'b1;
    conv_seen = 0;
    sleep(3'h1, 1'b1);
    chk("noise clocks", 8'h07, clks);
    chk("auto conversion", 8'h01, 8'(conv_seen));
    wake_line0_edge <= 1'b1;
    wake_other_io <= 1'b1;
    stays();
    wake_line0_edge <= 1'b0;
    wake_other_io <= 1'b0;
    wake_conv_done <= 1'b1;
    wake_time(4);
    wake_conv_done <= 1'b0;
    converter_enabled <= 1'b0;
    sleep(3'h2, 1'b1);
    chk("pdown clocks", 8'h00, clks);
    wake_line0_edge <= 1'b1;
    timer2_irq_mask_reg <= 2'h3;
    wake_timer2 <= 2'h3;
    stays();
    wake_line0_edge <= 1'b0;
    wake_timer2 <= 2'h0;
    timer2_irq_mask_reg <= 2'h0;
    lreq <= 1'b1;
    @(posedge sys_clk);
    lreq <= 1'b0;
    wake_time(SU + 3);
    timer2_running <= 1'b1;
    sleep(3'h3, 1'b1);
    chk("psave osc", 8'h05, {5'h0, main_osc_en, timer_osc_en,
      sync_only_t2_disp});
    wake_timer2 <= 2'h3;
    stays();
    timer2_irq_mask_reg <= 2'h3;
    global_irq_enable <= 1'b0;
    stays();
    global_irq_enable <= 1'b1;
    timer2_irq_mask_reg <= 2'h2;
    wake_time(SU + 4);
    wake_timer2 <= 2'h0;
    timer2_running <= 1'b0;
    crystal_selected <= 1'b1;
    sleep(3'h6, 1'b1);
    chk("standby clocks", 8'h01, clks);
    wake_start_cond <= 1'b1;
    wake_time(10);
    wake_start_cond <= 1'b0;
    print_verdict();
  end
endmodule : tb_top
